// File: hw/cts_supervision.sv
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module cts_supervision
    import cts_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic cycleStart,
    input wire cts_meas_t measuredMagnitude,
    input wire logic blockIn,
    output logic startOut,
    output logic blockedOut,
    output logic alarmOut,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Rising compare with drop-back at 97 % of the threshold
    function automatic logic aboveHys(input logic [15:0] mag, input logic [15:0] thr,
                                      input logic prev);
        logic [31:0] m;
        logic [31:0] t;
        m = {16'h0000, mag} * CTS_PCT;
        t = {16'h0000, thr};
        aboveHys = prev ? (m >= t * CTS_HYS_DROP) : (mag > thr);
    endfunction : aboveHys

    // Falling compare with release at 103 % of the threshold
    function automatic logic belowHys(input logic [15:0] mag, input logic [15:0] thr,
                                      input logic prev);
        logic [31:0] m;
        logic [31:0] t;
        m = {16'h0000, mag} * CTS_PCT;
        t = {16'h0000, thr};
        belowHys = prev ? (m <= t * CTS_HYS_RISE) : (mag < thr);
    endfunction : belowHys

    // Wraps an angle into -180..+180 degrees
    function automatic logic signed [16:0] wrapAng(input logic signed [16:0] a);
        logic signed [16:0] w;
        w = a;
        if (w > CTS_ANG_HALF) begin
            w = w - CTS_ANG_FULL;
        end else if (w < -CTS_ANG_HALF) begin
            w = w + CTS_ANG_FULL;
        end
        wrapAng = w;
    endfunction : wrapAng

    // Byte-lane merge for AXI writes
    function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] d,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        laneMerge = r;
    endfunction : laneMerge

    // ----------------------------------------------------------------
    // Blocking input synchroniser
    // ----------------------------------------------------------------
    logic blkMeta_r;
    logic blkSync_r;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            blkMeta_r <= 1'b0;
            blkSync_r <= 1'b0;
        end else begin
            blkMeta_r <= blockIn;
            blkSync_r <= blkMeta_r;
        end
    end

    // ----------------------------------------------------------------
    // Settings and AXI4-Lite slave
    // ----------------------------------------------------------------
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [15:0] highLim_r, highLim_nxt, lowLim_r, lowLim_nxt;
    logic [15:0] ratio_r, ratio_nxt, seqRatio_r, seqRatio_nxt;
    logic [15:0] sumThr_r, sumThr_nxt, delay_r, delay_nxt;
    logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
    logic [7:0] awAddr_r, awAddr_nxt;
    logic [31:0] wData_r, wData_nxt;
    logic [3:0] wStrb_r, wStrb_nxt;
    logic bValid_r, bValid_nxt, rValid_r, rValid_nxt;
    logic [1:0] bResp_r, bResp_nxt, rResp_r, rResp_nxt;
    logic [31:0] rData_r, rData_nxt;
    logic [31:0] statusWord;
    logic [15:0] diffMag_r;
    logic signed [16:0] diffAng_r;
    logic [31:0] wr;

    assign s_axi_awready = !awHeld_r && !bValid_r;
    assign s_axi_wready = !wHeld_r && !bValid_r;
    assign s_axi_arready = !rValid_r;
    assign s_axi_bvalid = bValid_r;
    assign s_axi_bresp = bResp_r;
    assign s_axi_rvalid = rValid_r;
    assign s_axi_rresp = rResp_r;
    assign s_axi_rdata = rData_r;

    // Address and data taken in either order; write once both are held
    always_comb begin
        ctrl_nxt = ctrl_r;
        highLim_nxt = highLim_r;
        lowLim_nxt = lowLim_r;
        ratio_nxt = ratio_r;
        seqRatio_nxt = seqRatio_r;
        sumThr_nxt = sumThr_r;
        delay_nxt = delay_r;
        awHeld_nxt = awHeld_r;
        wHeld_nxt = wHeld_r;
        awAddr_nxt = awAddr_r;
        wData_nxt = wData_r;
        wStrb_nxt = wStrb_r;
        bValid_nxt = bValid_r && !s_axi_bready;
        bResp_nxt = bResp_r;
        rValid_nxt = rValid_r && !s_axi_rready;
        rResp_nxt = rResp_r;
        rData_nxt = rData_r;
        wr = 32'h0000_0000;
        if (s_axi_awvalid && s_axi_awready) begin
            awHeld_nxt = 1'b1;
            awAddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeld_nxt = 1'b1;
            wData_nxt = s_axi_wdata;
            wStrb_nxt = s_axi_wstrb;
        end
        // Live update: new values steer the next program cycle
        if (awHeld_r && wHeld_r) begin
            awHeld_nxt = 1'b0;
            wHeld_nxt = 1'b0;
            bValid_nxt = 1'b1;
            bResp_nxt = CTS_RESP_OKAY;
            unique case (awAddr_r)
                CTS_ADDR_CTRL: ctrl_nxt = laneMerge(ctrl_r, wData_r, wStrb_r) & 32'h0000_003F;
                CTS_ADDR_HIGH: begin
                    wr = laneMerge({16'h0000, highLim_r}, wData_r, wStrb_r);
                    highLim_nxt = wr[15:0];
                end
                CTS_ADDR_LOW: begin
                    wr = laneMerge({16'h0000, lowLim_r}, wData_r, wStrb_r);
                    lowLim_nxt = wr[15:0];
                end
                CTS_ADDR_RATIO: begin
                    wr = laneMerge({16'h0000, ratio_r}, wData_r, wStrb_r);
                    ratio_nxt = wr[15:0];
                end
                CTS_ADDR_SEQ: begin
                    wr = laneMerge({16'h0000, seqRatio_r}, wData_r, wStrb_r);
                    seqRatio_nxt = wr[15:0];
                end
                CTS_ADDR_SUM: begin
                    wr = laneMerge({16'h0000, sumThr_r}, wData_r, wStrb_r);
                    sumThr_nxt = wr[15:0];
                end
                CTS_ADDR_DELAY: begin
                    wr = laneMerge({16'h0000, delay_r}, wData_r, wStrb_r);
                    delay_nxt = wr[15:0];
                end
                CTS_ADDR_STATUS, CTS_ADDR_DIFFMAG, CTS_ADDR_DIFFANG: ;
                default: bResp_nxt = CTS_RESP_SLVERR;
            endcase
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rValid_nxt = 1'b1;
            rResp_nxt = CTS_RESP_OKAY;
            unique case (s_axi_araddr)
                CTS_ADDR_CTRL: rData_nxt = ctrl_r;
                CTS_ADDR_HIGH: rData_nxt = {16'h0000, highLim_r};
                CTS_ADDR_LOW: rData_nxt = {16'h0000, lowLim_r};
                CTS_ADDR_RATIO: rData_nxt = {16'h0000, ratio_r};
                CTS_ADDR_SEQ: rData_nxt = {16'h0000, seqRatio_r};
                CTS_ADDR_SUM: rData_nxt = {16'h0000, sumThr_r};
                CTS_ADDR_DELAY: rData_nxt = {16'h0000, delay_r};
                CTS_ADDR_STATUS: rData_nxt = statusWord;
                CTS_ADDR_DIFFMAG: rData_nxt = {16'h0000, diffMag_r};
                CTS_ADDR_DIFFANG: rData_nxt = 32'(signed'(diffAng_r));
                default: begin
                    rData_nxt = 32'h0000_0000;
                    rResp_nxt = CTS_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ctrl_r <= 32'h0000_0000;
            highLim_r <= CTS_RST_HIGH;
            lowLim_r <= CTS_RST_LOW;
            ratio_r <= CTS_RST_RATIO;
            seqRatio_r <= CTS_RST_SEQ;
            sumThr_r <= CTS_RST_SUM;
            delay_r <= CTS_RST_DELAY;
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
            bValid_r <= 1'b0;
            bResp_r <= CTS_RESP_OKAY;
            rValid_r <= 1'b0;
            rResp_r <= CTS_RESP_OKAY;
            rData_r <= 32'h0000_0000;
        end else begin
            ctrl_r <= ctrl_nxt;
            highLim_r <= highLim_nxt;
            lowLim_r <= lowLim_nxt;
            ratio_r <= ratio_nxt;
            seqRatio_r <= seqRatio_nxt;
            sumThr_r <= sumThr_nxt;
            delay_r <= delay_nxt;
            awHeld_r <= awHeld_nxt;
            wHeld_r <= wHeld_nxt;
            awAddr_r <= awAddr_nxt;
            wData_r <= wData_nxt;
            wStrb_r <= wStrb_nxt;
            bValid_r <= bValid_nxt;
            bResp_r <= bResp_nxt;
            rValid_r <= rValid_nxt;
            rResp_r <= rResp_nxt;
            rData_r <= rData_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Pick-up conditions, all integer in 0.01
    // ----------------------------------------------------------------
    logic [1:0] resSel;
    logic polSub, forceEn;
    logic [1:0] forceSt;
    logic resUsed;
    logic [15:0] resMag, pMax, pMin;
    logic signed [16:0] effAng, angD;
    logic [15:0] diffMag;
    logic [2:0] hi_r, hi_nxt, lo_r, lo_nxt, ab_r, ab_nxt;
    logic resAb_r, resAb_nxt, sum_r, sum_nxt, pick_r, pick_nxt;
    logic [15:0] diffMag_nxt;
    logic signed [16:0] diffAng_nxt;
    logic [15:0] ph [3];

    assign resSel = ctrl_r[CTS_CTRL_SEL_LSB +: 2];
    assign polSub = ctrl_r[CTS_CTRL_POL_BIT];
    assign forceEn = ctrl_r[CTS_CTRL_FEN_BIT];
    assign forceSt = ctrl_r[CTS_CTRL_FST_LSB +: 2];
    assign resUsed = (resSel == CTS_SEL_ONE) || (resSel == CTS_SEL_TWO);
    assign ph[0] = measuredMagnitude.phA;
    assign ph[1] = measuredMagnitude.phB;
    assign ph[2] = measuredMagnitude.phC;

    // Residual phasor with polarity; opposing phasors mean a small difference
    always_comb begin
        resMag = (resSel == CTS_SEL_TWO) ? measuredMagnitude.resTwo : measuredMagnitude.resOne;
        effAng = (resSel == CTS_SEL_TWO) ? 17'(measuredMagnitude.resTwoAng)
                                         : 17'(measuredMagnitude.resOneAng);
        if (polSub) begin
            effAng = wrapAng(effAng + CTS_ANG_HALF);
        end
        angD = wrapAng(17'(measuredMagnitude.sumAng) - effAng);
        if (angD > CTS_ANG_QUART || angD < -CTS_ANG_QUART) begin
            diffMag = (measuredMagnitude.sumMag > resMag) ? measuredMagnitude.sumMag - resMag
                                                           : resMag - measuredMagnitude.sumMag;
        end else begin
            diffMag = measuredMagnitude.sumMag + resMag;
        end
        pMax = ph[0];
        pMin = ph[0];
        for (int i = 1; i < 3; i++) begin
            if (ph[i] > pMax) pMax = ph[i];
            if (ph[i] < pMin) pMin = ph[i];
        end
    end

    // Level comparisons with hysteresis, ratio checks without; refreshed once per program cycle
    always_comb begin
        hi_nxt = hi_r;
        lo_nxt = lo_r;
        ab_nxt = ab_r;
        resAb_nxt = resAb_r;
        sum_nxt = sum_r;
        pick_nxt = pick_r;
        diffMag_nxt = diffMag_r;
        diffAng_nxt = diffAng_r;
        if (cycleStart) begin
            for (int i = 0; i < 3; i++) begin
                hi_nxt[i] = aboveHys(ph[i], highLim_r, hi_r[i]);
                ab_nxt[i] = aboveHys(ph[i], lowLim_r, ab_r[i]);
                lo_nxt[i] = belowHys(ph[i], lowLim_r, lo_r[i]);
            end
            resAb_nxt = resUsed && aboveHys(resMag, lowLim_r, resAb_r);
            sum_nxt = resUsed && aboveHys(diffMag, sumThr_r, sum_r);
            diffMag_nxt = resUsed ? diffMag : 16'h0000;
            diffAng_nxt = resUsed ? angD : 17'sh0_0000;
            pick_nxt = !(|hi_nxt)
                && ((|ab_nxt) || resAb_nxt) && (|lo_nxt)
                && ({16'h0000, pMin} * CTS_PCT_FULL < {16'h0000, ratio_r} * {16'h0000, pMax})
                && ({16'h0000, measuredMagnitude.negSeq} * CTS_PCT_FULL
                    > {16'h0000, seqRatio_r} * {16'h0000, measuredMagnitude.posSeq})
                && (!resUsed || sum_nxt);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            hi_r <= 3'h0;
            lo_r <= 3'h0;
            ab_r <= 3'h0;
            resAb_r <= 1'b0;
            sum_r <= 1'b0;
            pick_r <= 1'b0;
            diffMag_r <= 16'h0000;
            diffAng_r <= 17'sh0_0000;
        end else begin
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
            ab_r <= ab_nxt;
            resAb_r <= resAb_nxt;
            sum_r <= sum_nxt;
            pick_r <= pick_nxt;
            diffMag_r <= diffMag_nxt;
            diffAng_r <= diffAng_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Status machine and delay
    // ----------------------------------------------------------------
    cts_state_t state_r, state_nxt;
    logic blkSample_r, blkSample_nxt, evalPend_r;
    logic dtDone;

    // Timer runs only in the start state, so late blocking releases it
    cts_dt_timer u_timer (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .tick(evalPend_r),
        .run(state_r == CTS_ST_START),
        .delaySteps(delay_r),
        .done(dtDone)
    );

    // Block level is latched at cycle start and used for that cycle only
    always_comb begin
        blkSample_nxt = cycleStart ? blkSync_r : blkSample_r;
        state_nxt = state_r;
        if (evalPend_r) begin
            unique case (state_r)
                CTS_ST_IDLE: begin
                    if (pick_r && blkSample_r) state_nxt = CTS_ST_BLOCKED;
                    else if (pick_r) state_nxt = CTS_ST_START;
                end
                CTS_ST_START: begin
                    if (!pick_r) state_nxt = CTS_ST_IDLE;
                    else if (blkSample_r) state_nxt = CTS_ST_BLOCKED;
                    else if (dtDone) state_nxt = CTS_ST_ALARM;
                end
                CTS_ST_BLOCKED: begin
                    if (!pick_r) state_nxt = CTS_ST_IDLE;
                    else if (!blkSample_r) state_nxt = CTS_ST_START;
                end
                CTS_ST_ALARM: begin
                    if (!pick_r) state_nxt = CTS_ST_IDLE;
                    else if (blkSample_r) state_nxt = CTS_ST_BLOCKED;
                end
                default: state_nxt = CTS_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_r <= CTS_ST_IDLE;
            blkSample_r <= 1'b0;
            evalPend_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            blkSample_r <= blkSample_nxt;
            evalPend_r <= cycleStart;
        end
    end

    // Registered outputs; forcing overrides the computed status
    logic start_r, blocked_r, alarm_r;
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            start_r <= 1'b0;
            blocked_r <= 1'b0;
            alarm_r <= 1'b0;
        end else if (forceEn) begin
            start_r <= 1'b0;
            blocked_r <= (forceSt == CTS_FORCE_BLOCKED);
            alarm_r <= (forceSt == CTS_FORCE_ALARM);
        end else begin
            start_r <= (state_nxt == CTS_ST_START) || (state_nxt == CTS_ST_ALARM);
            blocked_r <= (state_nxt == CTS_ST_BLOCKED);
            alarm_r <= (state_nxt == CTS_ST_ALARM);
        end
    end

    assign startOut = start_r;
    assign blockedOut = blocked_r;
    assign alarmOut = alarm_r;
    assign statusWord = {17'h0_0000, sum_r, resAb_r, lo_r, ab_r, hi_r, pick_r,
                         alarm_r, blocked_r, start_r};

endmodule : cts_supervision
`default_nettype wire

// File: hw/cts_pkg.sv
package cts_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] CTS_ADDR_CTRL = 8'h00;
    localparam logic [7:0] CTS_ADDR_HIGH = 8'h04;
    localparam logic [7:0] CTS_ADDR_LOW = 8'h08;
    localparam logic [7:0] CTS_ADDR_RATIO = 8'h0C;
    localparam logic [7:0] CTS_ADDR_SEQ = 8'h10;
    localparam logic [7:0] CTS_ADDR_SUM = 8'h14;
    localparam logic [7:0] CTS_ADDR_DELAY = 8'h18;
    localparam logic [7:0] CTS_ADDR_STATUS = 8'h1C;
    localparam logic [7:0] CTS_ADDR_DIFFMAG = 8'h20;
    localparam logic [7:0] CTS_ADDR_DIFFANG = 8'h24;

    // Control word fields
    localparam int CTS_CTRL_SEL_LSB = 0;
    localparam int CTS_CTRL_POL_BIT = 2;
    localparam int CTS_CTRL_FEN_BIT = 3;
    localparam int CTS_CTRL_FST_LSB = 4;

    // Residual channel choice and forced status codes
    localparam logic [1:0] CTS_SEL_NONE = 2'h0;
    localparam logic [1:0] CTS_SEL_ONE = 2'h1;
    localparam logic [1:0] CTS_SEL_TWO = 2'h2;
    localparam logic [1:0] CTS_FORCE_NORMAL = 2'h0;
    localparam logic [1:0] CTS_FORCE_ALARM = 2'h1;
    localparam logic [1:0] CTS_FORCE_BLOCKED = 2'h2;

    // Reset values: currents in 0.01 In, ratios in 0.01 %, delay in steps
    localparam logic [15:0] CTS_RST_HIGH = 16'h0078;
    localparam logic [15:0] CTS_RST_LOW = 16'h000A;
    localparam logic [15:0] CTS_RST_RATIO = 16'h03E8;
    localparam logic [15:0] CTS_RST_SEQ = 16'h1324;
    localparam logic [15:0] CTS_RST_SUM = 16'h000A;
    localparam int CTS_DELAY_STEP_US = 5000;
    localparam int CTS_DELAY_DEF_US = 500000;
    localparam logic [15:0] CTS_RST_DELAY = 16'(CTS_DELAY_DEF_US / CTS_DELAY_STEP_US);

    // Hysteresis and scaling constants
    localparam logic [31:0] CTS_HYS_DROP = 32'h0000_0061;
    localparam logic [31:0] CTS_HYS_RISE = 32'h0000_0067;
    localparam logic [31:0] CTS_PCT = 32'h0000_0064;
    localparam logic [31:0] CTS_PCT_FULL = 32'h0000_2710;
    localparam logic signed [16:0] CTS_ANG_HALF = 17'sh0_4650;
    localparam logic signed [16:0] CTS_ANG_FULL = 17'sh0_8CA0;
    localparam logic signed [16:0] CTS_ANG_QUART = 17'sh0_2328;

    // AXI responses
    localparam logic [1:0] CTS_RESP_OKAY = 2'h0;
    localparam logic [1:0] CTS_RESP_SLVERR = 2'h2;

    // Magnitudes in 0.01 In, angles in signed 0.01 degree
    typedef struct packed {
        logic [15:0] phA;
        logic [15:0] phB;
        logic [15:0] phC;
        logic [15:0] resOne;
        logic [15:0] resTwo;
        logic [15:0] posSeq;
        logic [15:0] negSeq;
        logic [15:0] sumMag;
        logic signed [15:0] sumAng;
        logic signed [15:0] resOneAng;
        logic signed [15:0] resTwoAng;
    } cts_meas_t;

    typedef enum logic [3:0] {
        CTS_ST_IDLE = 4'b0001,
        CTS_ST_START = 4'b0010,
        CTS_ST_BLOCKED = 4'b0100,
        CTS_ST_ALARM = 4'b1000
    } cts_state_t;

endpackage : cts_pkg

// File: hw/cts_dt_timer.sv
`timescale 1ns/1ps
`default_nettype none
module cts_dt_timer
    import cts_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic tick,
    input wire logic run,
    input wire logic [15:0] delaySteps,
    output logic done
);

    logic [15:0] count_r;
    logic [15:0] count_nxt;

    // Counts program-cycle ticks while running; stopping clears it
    always_comb begin
        count_nxt = count_r;
        if (!run) begin
            count_nxt = 16'h0000;
        end else if (tick && count_r != 16'hFFFF) begin
            count_nxt = count_r + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            count_r <= 16'h0000;
        end else begin
            count_r <= count_nxt;
        end
    end

    // Definite time only: no curve, just a compare
    // The strobe that entered start is the first step, so add one
    assign done = run && ({1'b0, count_r} + 17'h0_0001 >= {1'b0, delaySteps});

endmodule : cts_dt_timer
`default_nettype wire

// File: tb/cts_props.sv
`timescale 1ns/1ps
`default_nettype none
module cts_props
    import cts_pkg::*;
(
    input wire logic ref_clk, reset_n, cycleStart, startOut, blockedOut, alarmOut,
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic s_axi_rvalid, s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    // ----
    // Output and bus relations
    // ----
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    sequence s_rd; s_axi_arvalid && s_axi_arready; endsequence
    property p_excl; !(startOut && blockedOut); endproperty
    property p_start; $rose(startOut) |-> $past(cycleStart, 2); endproperty
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_arrdy; s_axi_rvalid |-> !s_axi_arready; endproperty
    property p_awrdy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    property p_wresp; s_wr |-> ##[1:2] s_axi_bvalid; endproperty
    property p_rresp; s_rd |=> s_axi_rvalid; endproperty
    a_excl: assert property (p_excl) else $error("start and blocked together");
    a_start: assert property (p_start) else $error("start off strobe");
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    a_rhold: assert property (p_rhold) else $error("read answer unstable");
    a_arrdy: assert property (p_arrdy) else $error("arready during rvalid");
    a_awrdy: assert property (p_awrdy) else $error("write taken during bvalid");
    a_wresp: assert property (p_wresp) else $error("no write answer");
    a_rresp: assert property (p_rresp) else $error("no read answer");
endmodule : cts_props
bind cts_supervision cts_props u_props (.*);
`default_nettype wire

// File: tb/cts_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module cts_front_end
    import cts_pkg::*;
#(parameter int PERIOD = 16)
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire cts_meas_t want,
    input wire logic blk,
    output logic cycleStart,
    output cts_meas_t measuredMagnitude,
    output logic blockIn
);
    int cnt_r;
    // Short program cycle keeps the run brief
    always_ff @(posedge ref_clk) begin
        cnt_r <= (!reset_n || cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
        cycleStart <= reset_n && cnt_r == PERIOD - 1;
    end
    // Values only valid with the strobe, garbage otherwise
    assign measuredMagnitude = cycleStart ? want : ~want;
    assign blockIn = blk;
endmodule : cts_front_end
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import cts_pkg::*; ;
    logic ref_clk, reset_n, blk, cycleStart, blockIn, startOut, blockedOut, alarmOut;
    cts_meas_t want, measuredMagnitude;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, sel;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int bad_count, checked, seed = 71, dly, cnt, c;
    int rv[6] = '{120, 10, 1000, 4900, 10, 100};
    bit st, al, bl, p, pol;
    cts_supervision u_cts_supervision (.*);
    cts_front_end u_cts_front_end (.*);
    // ----
    // Clock, watchdog, helpers
    // ----
    initial begin ref_clk = 0; forever #20 ref_clk = ~ref_clk; end
    initial begin #2000000; bad_count++; stop_test; end
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        checked++;
        if (s !== e) begin bad_count++; $display("mismatch %s exp %h seen %h", n, e, s); end
    endtask : chk
    task automatic stop_test;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    // Readies sampled mid-cycle, released just after the taking edge
    task automatic wr(logic [7:0] a, logic [31:0] v, logic [1:0] e);
        logic x, y, z;
        @(posedge ref_clk);
        s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(negedge ref_clk); x = s_axi_awready; y = s_axi_wready; z = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge ref_clk); if (x) s_axi_awvalid <= 0; if (y) s_axi_wvalid <= 0;
        end while (!z);
        s_axi_bready <= 0;
        chk("bresp", r, e);
    endtask : wr
    task automatic rd(logic [7:0] a);
        logic x, z;
        @(posedge ref_clk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin
            @(negedge ref_clk); x = s_axi_arready; z = s_axi_rvalid; r = s_axi_rresp;
            d = s_axi_rdata;
            @(posedge ref_clk); if (x) s_axi_arvalid <= 0;
        end while (!z);
        s_axi_rready <= 0;
    endtask : rd
    // Integer pick-up model at default thresholds
    function automatic bit pk(int a, b, c, n, s, q);
        int mx, mn;
        mx = a > b ? a : b; mx = mx > c ? mx : c;
        mn = a < b ? a : b; mn = mn < c ? mn : c;
        return mx <= 120 && mx > 10 && mn < 10 && mn * 10 < mx && n > 49
            && (sel == 0 || (pol ? (s > q ? s - q : q - s) : s + q) > 10);
    endfunction : pk
    // One program cycle: apply, wait strobe plus three edges, compare
    task automatic step(int a, b, c, n, s, q, bit k);
        @(posedge ref_clk);
        want <= {16'(a), 16'(b), 16'(c), 16'(q), 16'h0000, 16'h0064, 16'(n), 16'(s), 48'h0};
        blk <= k;
        @(negedge ref_clk iff cycleStart);
        repeat (3) @(posedge ref_clk);
        #1;
        p = pk(a, b, c, n, s, q);
        if (!p || k) begin st = 0; al = 0; cnt = 0; end
        else if (!st) st = 1;
        else begin cnt++; al = al || cnt >= dly; end
        bl = p && k;
        chk("start", startOut, st);
        chk("blocked", blockedOut, bl);
        chk("alarm", alarmOut, al);
    endtask : step
    // ----
    // Main sequence
    // ----
    initial begin
        {reset_n, blk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata, want, sel} = 0;
        s_axi_wstrb = 4'hF;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1;
        foreach (rv[i]) begin rd(8'h04 + 8'(4 * i)); chk("reset", d, rv[i]); end
        rd(8'h28); chk("rresp", r, CTS_RESP_SLVERR);
        wr(8'h2C, 1, CTS_RESP_SLVERR);
        dly = 3; wr(CTS_ADDR_DELAY, 3, CTS_RESP_OKAY);
        $display("end registers");
        repeat (5) step(100, 100, 0, 50, 0, 0, 0);
        step(100, 100, 20, 50, 0, 0, 0);
        step(130, 100, 0, 50, 0, 0, 0);
        step(8, 8, 0, 50, 0, 0, 0);
        step(100, 100, 0, 40, 0, 0, 0);
        $display("end thresholds");
        repeat (12) begin
            c = ($random(seed) & 1) ? 20 + ($random(seed) & 63) : $random(seed) & 7;
            step(100, 100, c, c < 10 ? 50 : 0, 0, 0, 0);
        end
        step(100, 100, 0, 50, 0, 0, 0); step(100, 100, 0, 50, 0, 0, 1);
        step(100, 100, 0, 50, 0, 0, 1); step(100, 100, 0, 50, 0, 0, 0);
        $display("end blocking");
        sel = CTS_SEL_ONE;
        repeat (2) begin
            wr(CTS_ADDR_CTRL, {29'h0, pol, sel}, CTS_RESP_OKAY);
            step(100, 100, 0, 50, 50, 50, 0);
            rd(CTS_ADDR_DIFFMAG); chk("diffmag", d, pol ? 0 : 100);
            rd(CTS_ADDR_DIFFANG); chk("diffang", d, pol ? -18000 : 0);
            pol = !pol;
        end
        $display("end residual");
        for (int f = 0; f < 3; f++) begin
            wr(CTS_ADDR_CTRL, 32'(8 + f * 16), CTS_RESP_OKAY);
            repeat (2) @(posedge ref_clk);
            #1;
            chk("force", {startOut, blockedOut, alarmOut}, {1'b0, f == 2, f == 1});
        end
        $display("end forcing");
        stop_test;
    end
endmodule : tb_top
`default_nettype wire
